// *** rtl/prox_pkg.sv ***
// Notes on behaviour
// R1: host sets bit 7 of a command byte; kinds 00 and 01 then update the pointer.
// R2: bits 6:5 pick the kind: 00 repeated, 01 auto-increment, 11 special, 10 unused.
// R3: repeated-byte kind keeps the pointer fixed for every data access.
// R4: auto-increment kind advances the pointer after each data byte.
// R5: bits 4:0 hold the register address, or a function code; 00000 does nothing.
// R6: function code 00101 clears a pending interrupt once, self clearing.
// R7: interrupt enable bit 5 low means no interrupt is ever raised.
// R8: wait enable bit 3 turns the wait timer on or off.
// R9: proximity enable bits 2:1: 11b measures, 00b stops.
// R10: host should program the wait period before enabling proximity.
// R11: power bit 0 runs the internal timebase; clearing it stops everything.
// R12: at least one 2.72 ms delay after power-on before any measurement.
// R13: host writes zero to enable bits 7:6 and 4.
// R14: integration runs 256 minus value steps of 2.72 ms; 0xFF is one.
// R15: wait runs 256 minus value steps; 0xFF one step, 0x00 256 steps.
// R16: wait extend stretches every wait step twelvefold.
// R17: result below low threshold or above high threshold is out of range.
// R18: thresholds are byte pairs at 0x08/0x09 and 0x0A/0x0B.
// R19: persistence 0 fires every cycle; 1 to 15 needs that many in a row.
// R20: sequence: start, accumulate, convert, wait check, wait, delay, restart.
// R21: a byte with bit 7 clear is data for the stored pointer.
// R22: pointer and kind persist across transactions until a new command.
// R23: interrupt clear leaves pointer and stored registers untouched.
package prox_pkg;
    localparam logic [4:0] OFS_FUNCTION_ENABLES = 5'h00;
    localparam logic [4:0] OFS_INTEGRATION_PERIOD = 5'h02;
    localparam logic [4:0] OFS_WAIT_PERIOD = 5'h03;
    localparam logic [4:0] OFS_LOW_THRESH_LO_BYTE = 5'h08;
    localparam logic [4:0] OFS_LOW_THRESH_HI_BYTE = 5'h09;
    localparam logic [4:0] OFS_HIGH_THRESH_LO_BYTE = 5'h0A;
    localparam logic [4:0] OFS_HIGH_THRESH_HI_BYTE = 5'h0B;
    localparam logic [4:0] OFS_PERSIST = 5'h0C;
    localparam logic [4:0] OFS_CONFIG = 5'h0D;
    localparam logic [4:0] OFS_STATUS = 5'h13;
    localparam logic [4:0] OFS_RESULT_LO = 5'h18;
    localparam logic [4:0] OFS_RESULT_HI = 5'h19;

    localparam int CMD_SEL_BIT = 7;
    localparam int KIND_HI = 6;
    localparam int KIND_LO = 5;
    localparam int ADDR_HI = 4;
    localparam int IRQ_EN_BIT = 5;
    localparam int WAIT_EN_BIT = 3;
    localparam int PROX_EN_HI = 2;
    localparam int PROX_EN_LO = 1;
    localparam int POWER_BIT = 0;
    localparam int WAIT_EXT_BIT = 1;
    localparam int PERSIST_HI = 7;
    localparam int PERSIST_LO = 4;
    localparam int STATUS_IRQ_BIT = 5;

    localparam logic [1:0] KIND_REPEAT = 2'h0;
    localparam logic [1:0] KIND_AUTO = 2'h1;
    localparam logic [1:0] KIND_SPECIAL = 2'h3;
    localparam logic [4:0] FUNC_NOP = 5'h00;
    localparam logic [4:0] FUNC_IRQ_CLEAR = 5'h05;
    localparam logic [1:0] PROX_ON = 2'h3;

    localparam logic [7:0] RST_ENABLES = 8'h00;
    localparam logic [7:0] RST_INTEGRATION = 8'hFF;
    localparam logic [7:0] RST_WAIT = 8'hFF;
    localparam logic [7:0] RST_OTHER = 8'h00;
    localparam logic [4:0] RST_POINTER = 5'h00;

    localparam int CLK_PERIOD_NS = 25;
    localparam int STEP_TIME_NS = 2720000;
    localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] WAIT_EXT_LAST = 4'hB;
    localparam logic [8:0] PERIOD_FULL = 9'h100;
    localparam logic [3:0] PERSIST_MAX = 4'hF;

    typedef enum logic [2:0] {
        SEQ_SLEEP,
        SEQ_START_DELAY,
        SEQ_START,
        SEQ_ACCUM,
        SEQ_CONVERT,
        SEQ_WAIT_CHECK,
        SEQ_WAIT,
        SEQ_WAIT_DELAY
    } seq_t;

    typedef struct packed {
        logic valid;
        logic first;
        logic [7:0] data;
    } host_wr_t;

    typedef struct packed {
        logic [15:0][7:0] regs;
        logic [4:0] pointer;
        logic [1:0] kind;
        logic [7:0] rd_data;
        seq_t seq;
        logic [31:0] step_cnt;
        logic [8:0] period_cnt;
        logic [3:0] ext_cnt;
        logic [3:0] persist_cnt;
        logic irq;
        logic [15:0] result;
    } prox_state_t;
endpackage : prox_pkg

// *** rtl/proximity_control_registers.sv ***
`timescale 1ns/10ps
module proximity_control_registers #(
    parameter int STEP_CYCLES = prox_pkg::STEP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire prox_pkg::host_wr_t host_wr,
    input wire logic host_rd,
    output logic [7:0] host_rd_data,
    input wire logic [15:0] prox_result,
    output logic osc_run,
    output logic integrating,
    output logic prox_irq
);
    prox_pkg::prox_state_t s_r;
    prox_pkg::prox_state_t s_nxt;

    logic power_on;
    logic prox_enable;
    logic wait_enable;
    logic prox_irq_enable;
    logic wait_extend;
    logic [3:0] persist_count;
    logic [15:0] low_thresh;
    logic [15:0] high_thresh;
    logic step_tick;
    logic out_of_range;
    logic [3:0] run_len;
    logic fire;
    logic clear_req;
    logic advance;

    function automatic logic writable(input logic [4:0] a);
        unique case (a)
            prox_pkg::OFS_FUNCTION_ENABLES, prox_pkg::OFS_INTEGRATION_PERIOD,
            prox_pkg::OFS_WAIT_PERIOD, prox_pkg::OFS_LOW_THRESH_LO_BYTE,
            prox_pkg::OFS_LOW_THRESH_HI_BYTE, prox_pkg::OFS_HIGH_THRESH_LO_BYTE,
            prox_pkg::OFS_HIGH_THRESH_HI_BYTE, prox_pkg::OFS_PERSIST,
            prox_pkg::OFS_CONFIG: writable = 1'b1;
            default: writable = 1'b0;
        endcase
    endfunction : writable

    always_comb
    begin
        power_on = s_r.regs[prox_pkg::OFS_FUNCTION_ENABLES[3:0]][prox_pkg::POWER_BIT]; // R11
        prox_enable = s_r.regs[prox_pkg::OFS_FUNCTION_ENABLES[3:0]]
            [prox_pkg::PROX_EN_HI:prox_pkg::PROX_EN_LO] == prox_pkg::PROX_ON; // R9
        wait_enable = s_r.regs[prox_pkg::OFS_FUNCTION_ENABLES[3:0]][prox_pkg::WAIT_EN_BIT]; // R8
        prox_irq_enable = s_r.regs[prox_pkg::OFS_FUNCTION_ENABLES[3:0]][prox_pkg::IRQ_EN_BIT];
        wait_extend = s_r.regs[prox_pkg::OFS_CONFIG[3:0]][prox_pkg::WAIT_EXT_BIT];
        persist_count = s_r.regs[prox_pkg::OFS_PERSIST[3:0]]
            [prox_pkg::PERSIST_HI:prox_pkg::PERSIST_LO];
        low_thresh = {s_r.regs[prox_pkg::OFS_LOW_THRESH_HI_BYTE[3:0]],
            s_r.regs[prox_pkg::OFS_LOW_THRESH_LO_BYTE[3:0]]}; // R18
        high_thresh = {s_r.regs[prox_pkg::OFS_HIGH_THRESH_HI_BYTE[3:0]],
            s_r.regs[prox_pkg::OFS_HIGH_THRESH_LO_BYTE[3:0]]}; // R18
    end

    assign step_tick = s_r.step_cnt == 32'(STEP_CYCLES - 1);
    assign out_of_range = prox_result < low_thresh || prox_result > high_thresh; // R17
    assign run_len = (s_r.persist_cnt == prox_pkg::PERSIST_MAX) ?
        prox_pkg::PERSIST_MAX : s_r.persist_cnt + 4'h1;

    always_comb
    begin
        s_nxt = s_r;
        clear_req = 1'b0;
        advance = 1'b0;
        fire = 1'b0;

        // host side: command decode, data writes, reads
        if (host_wr.valid)
        begin
            if (host_wr.first && host_wr.data[prox_pkg::CMD_SEL_BIT]) // R1
            begin
                unique case (host_wr.data[prox_pkg::KIND_HI:prox_pkg::KIND_LO]) // R2
                    prox_pkg::KIND_REPEAT, prox_pkg::KIND_AUTO:
                    begin
                        s_nxt.pointer = host_wr.data[prox_pkg::ADDR_HI:0]; // R5
                        s_nxt.kind = host_wr.data[prox_pkg::KIND_HI:prox_pkg::KIND_LO]; // R22
                    end
                    prox_pkg::KIND_SPECIAL:
                    begin
                        // pointer, kind and registers stay as they are
                        clear_req = host_wr.data[prox_pkg::ADDR_HI:0]
                            == prox_pkg::FUNC_IRQ_CLEAR; // R6 R23
                    end
                    default:
                    begin
                        // reserved kind: ignored so a stray byte cannot corrupt the pointer
                    end
                endcase
            end
            else
            begin
                if (writable(s_r.pointer)) // R21
                begin
                    s_nxt.regs[s_r.pointer[3:0]] = host_wr.data;
                end
                advance = 1'b1;
            end
        end
        else if (host_rd)
        begin
            if (writable(s_r.pointer))
            begin
                s_nxt.rd_data = s_r.regs[s_r.pointer[3:0]];
            end
            else
            begin
                unique case (s_r.pointer)
                    prox_pkg::OFS_STATUS:
                        s_nxt.rd_data = 8'(s_r.irq) << prox_pkg::STATUS_IRQ_BIT;
                    prox_pkg::OFS_RESULT_LO: s_nxt.rd_data = s_r.result[7:0];
                    prox_pkg::OFS_RESULT_HI: s_nxt.rd_data = s_r.result[15:8];
                    default: s_nxt.rd_data = 8'h00;
                endcase
            end
            advance = 1'b1;
        end
        if (advance && s_r.kind == prox_pkg::KIND_AUTO)
        begin
            s_nxt.pointer = s_r.pointer + 5'h01; // R4
        end
        // repeated-byte kind leaves the pointer where it is R3

        // measurement sequencer
        s_nxt.step_cnt = step_tick ? 32'h0000_0000 : s_r.step_cnt + 32'h0000_0001;
        unique case (s_r.seq)
            prox_pkg::SEQ_SLEEP:
            begin
                s_nxt.step_cnt = 32'h0000_0000;
                if (power_on)
                begin
                    s_nxt.seq = prox_pkg::SEQ_START_DELAY; // R12
                end
            end
            prox_pkg::SEQ_START_DELAY:
            begin
                if (step_tick)
                begin
                    s_nxt.seq = prox_pkg::SEQ_START; // R12
                end
            end
            prox_pkg::SEQ_START:
            begin
                s_nxt.step_cnt = 32'h0000_0000;
                if (prox_enable)
                begin
                    s_nxt.period_cnt = prox_pkg::PERIOD_FULL
                        - {1'b0, s_r.regs[prox_pkg::OFS_INTEGRATION_PERIOD[3:0]]}; // R14
                    s_nxt.seq = prox_pkg::SEQ_ACCUM; // R20
                end
                else
                begin
                    s_nxt.seq = prox_pkg::SEQ_WAIT_CHECK; // R20
                end
            end
            prox_pkg::SEQ_ACCUM:
            begin
                if (step_tick)
                begin
                    s_nxt.period_cnt = s_r.period_cnt - 9'h001; // R14
                    if (s_r.period_cnt == 9'h001)
                    begin
                        s_nxt.seq = prox_pkg::SEQ_CONVERT;
                    end
                end
            end
            prox_pkg::SEQ_CONVERT:
            begin
                s_nxt.result = prox_result;
                if (persist_count == 4'h0)
                begin
                    fire = 1'b1; // R19
                end
                else if (out_of_range)
                begin
                    s_nxt.persist_cnt = run_len;
                    fire = run_len >= persist_count; // R19
                end
                else
                begin
                    s_nxt.persist_cnt = 4'h0;
                end
                s_nxt.seq = prox_pkg::SEQ_WAIT_CHECK; // R20
            end
            prox_pkg::SEQ_WAIT_CHECK:
            begin
                s_nxt.step_cnt = 32'h0000_0000;
                s_nxt.ext_cnt = 4'h0;
                if (wait_enable) // R8
                begin
                    s_nxt.period_cnt = prox_pkg::PERIOD_FULL
                        - {1'b0, s_r.regs[prox_pkg::OFS_WAIT_PERIOD[3:0]]}; // R15
                    s_nxt.seq = prox_pkg::SEQ_WAIT;
                end
                else
                begin
                    s_nxt.seq = prox_pkg::SEQ_START;
                end
            end
            prox_pkg::SEQ_WAIT:
            begin
                if (step_tick)
                begin
                    if (wait_extend && s_r.ext_cnt != prox_pkg::WAIT_EXT_LAST)
                    begin
                        s_nxt.ext_cnt = s_r.ext_cnt + 4'h1; // R16
                    end
                    else
                    begin
                        s_nxt.ext_cnt = 4'h0;
                        s_nxt.period_cnt = s_r.period_cnt - 9'h001; // R15
                        if (s_r.period_cnt == 9'h001)
                        begin
                            s_nxt.seq = prox_pkg::SEQ_WAIT_DELAY; // R20
                        end
                    end
                end
            end
            prox_pkg::SEQ_WAIT_DELAY:
            begin
                if (step_tick)
                begin
                    s_nxt.seq = prox_pkg::SEQ_START; // R20
                end
            end
        endcase
        if (!power_on)
        begin
            // oscillator stopped: timers halt, captured state is kept
            s_nxt.seq = prox_pkg::SEQ_SLEEP; // R11
            s_nxt.step_cnt = 32'h0000_0000;
        end

        // clear first so a same-cycle event still lands
        if (clear_req)
        begin
            s_nxt.irq = 1'b0; // R6
        end
        if (fire && prox_irq_enable)
        begin
            s_nxt.irq = 1'b1; // R7
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            s_r.regs <= '0;
            s_r.regs[prox_pkg::OFS_FUNCTION_ENABLES[3:0]] <= prox_pkg::RST_ENABLES;
            s_r.regs[prox_pkg::OFS_INTEGRATION_PERIOD[3:0]] <= prox_pkg::RST_INTEGRATION;
            s_r.regs[prox_pkg::OFS_WAIT_PERIOD[3:0]] <= prox_pkg::RST_WAIT;
            s_r.pointer <= prox_pkg::RST_POINTER;
            s_r.kind <= prox_pkg::KIND_REPEAT;
            s_r.rd_data <= prox_pkg::RST_OTHER;
            s_r.seq <= prox_pkg::SEQ_SLEEP;
            s_r.step_cnt <= 32'h0000_0000;
            s_r.period_cnt <= 9'h000;
            s_r.ext_cnt <= 4'h0;
            s_r.persist_cnt <= 4'h0;
            s_r.irq <= 1'b0;
            s_r.result <= 16'h0000;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign host_rd_data = s_r.rd_data;
    assign osc_run = power_on;
    assign integrating = s_r.seq == prox_pkg::SEQ_ACCUM;
    assign prox_irq = s_r.irq;
endmodule : proximity_control_registers

// *** verification/host_model.sv ***
`timescale 1ns/10ps
module host_model (
    input wire logic sys_clk,
    output prox_pkg::host_wr_t host_wr,
    output logic host_rd,
    input wire logic [7:0] host_rd_data
);
    initial
    begin
        host_wr = '0;
        host_rd = 1'b0;
    end

    // released data shows the inverse so a stale byte never passes for a fresh one
    task automatic send(input logic first, input logic [7:0] d);
        @(posedge sys_clk);
        host_wr <= '{valid: 1'b1, first: first, data: d};
        @(posedge sys_clk);
        host_wr <= '{valid: 1'b0, first: 1'b0, data: ~d};
        #1;
    endtask : send

    task automatic command(input logic [1:0] kind, input logic [4:0] addr);
        send(1'b1, {1'b1, kind, addr});
    endtask : command

    task automatic recv(output logic [7:0] d);
        @(posedge sys_clk);
        host_rd <= 1'b1;
        @(posedge sys_clk);
        host_rd <= 1'b0;
        #1;
        d = host_rd_data;
    endtask : recv
endmodule : host_model

// *** verification/prox_checker.sv ***
`timescale 1ns/10ps
module prox_checker #(
    parameter int STEP_CYCLES = 8
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire prox_pkg::host_wr_t host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_rd_data,
    input wire logic [15:0] prox_result,
    input wire logic osc_run,
    input wire logic integrating,
    input wire logic prox_irq
);
    int on_cnt_r;
    int on_cnt_nxt;
    int run_cnt_r;
    int run_cnt_nxt;
    logic clr_byte;

    assign clr_byte = host_wr.valid && host_wr.first && host_wr.data == 8'hE5;

    always_comb
    begin
        on_cnt_nxt = osc_run ? on_cnt_r + ((on_cnt_r < STEP_CYCLES) ? 1 : 0) : 0;
        run_cnt_nxt = integrating ? run_cnt_r + 1 : 0;
    end

    always_ff @(posedge sys_clk)
    begin
        on_cnt_r <= resetn ? on_cnt_nxt : 0;
        run_cnt_r <= resetn ? run_cnt_nxt : 0;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence irq_rise;
        !prox_irq ##1 prox_irq;
    endsequence
    // a set in the convert cycle beats a clear, so that cycle is left out
    sequence clear_req;
        clr_byte && (integrating || !$past(integrating));
    endsequence

    a_irq_source: assert property (irq_rise |-> $past(integrating, 2) && !$past(integrating))
        else $error("interrupt rose outside a conversion");
    a_irq_clear: assert property (clear_req |=> !prox_irq)
        else $error("interrupt not cleared by clear byte");
    a_irq_holds: assert property (prox_irq && !clr_byte |=> prox_irq)
        else $error("interrupt dropped without a clear");
    a_rd_hold: assert property (!(host_rd && !host_wr.valid) |=> $stable(host_rd_data))
        else $error("read data changed without a read");
    a_power_cause: assert property ($changed(osc_run) |-> $past(host_wr.valid))
        else $error("oscillator changed without a write");
    a_sleep_idle: assert property (!osc_run && !$past(osc_run) |-> !integrating)
        else $error("integrating while powered down");
    a_start_delay: assert property (integrating |-> on_cnt_r >= STEP_CYCLES)
        else $error("integration before the start delay ran out");
    a_integ_steps: assert property ($fell(integrating) && osc_run
        |-> run_cnt_r > 0 && run_cnt_r % STEP_CYCLES == 0)
        else $error("integration not a whole number of steps");
endmodule : prox_checker

bind proximity_control_registers prox_checker #(.STEP_CYCLES(STEP_CYCLES)) chk (
    .sys_clk(sys_clk), .resetn(resetn), .host_wr(host_wr), .host_rd(host_rd),
    .host_rd_data(host_rd_data), .prox_result(prox_result), .osc_run(osc_run),
    .integrating(integrating), .prox_irq(prox_irq));

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    localparam int STEP = 8;
    logic sys_clk;
    logic resetn;
    logic [15:0] prox_result;
    logic [7:0] host_rd_data;
    logic osc_run;
    logic integrating;
    logic prox_irq;
    logic host_rd;
    prox_pkg::host_wr_t host_wr;
    int failures;
    int checked;
    int n;
    int k;
    logic [7:0] rd;
    logic [15:0] r;
    logic [7:0] val [4];
    logic [4:0] offs [8] = '{5'h00, 5'h02, 5'h03, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h01};
    logic [7:0] rstv [8] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [15:0] corner [4] = '{16'h0100, 16'h0200, 16'h00FF, 16'h0201};

    host_model host (.sys_clk(sys_clk), .host_wr(host_wr), .host_rd(host_rd),
        .host_rd_data(host_rd_data));
    proximity_control_registers #(.STEP_CYCLES(STEP)) uut (.sys_clk(sys_clk), .resetn(resetn),
        .host_wr(host_wr), .host_rd(host_rd), .host_rd_data(host_rd_data),
        .prox_result(prox_result), .osc_run(osc_run), .integrating(integrating),
        .prox_irq(prox_irq));

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_byte

    task automatic check_cycles(input int got, input int exp);
        checked++;
        if (got != exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_cycles

    function automatic logic outside(input logic [15:0] v);
        return (v < 16'h0100) || (v > 16'h0200);
    endfunction : outside

    task automatic wait_on(input logic lvl);
        int i;
        for (i = 0; i < 4000; i++)
        begin
            @(posedge sys_clk);
            #1;
            if (integrating === lvl)
                return;
        end
        failures++;
        report_and_stop();
    endtask : wait_on

    task automatic run_len(input logic lvl, output int cnt);
        cnt = 0;
        while (integrating === lvl && cnt < 4000)
        begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end
        if (cnt >= 4000)
        begin
            failures++;
            report_and_stop();
        end
    endtask : run_len

    // irq as seen just after the next conversion
    task automatic next_convert(output logic v);
        wait_on(1'b1);
        wait_on(1'b0);
        @(posedge sys_clk);
        #1;
        v = prox_irq;
    endtask : next_convert

    task automatic rd_at(input logic [4:0] a, output logic [7:0] d);
        host.command(prox_pkg::KIND_REPEAT, a);
        host.recv(d);
    endtask : rd_at

    task automatic wr_at(input logic [4:0] a, input logic [7:0] d);
        host.command(prox_pkg::KIND_REPEAT, a);
        host.send(1'b0, d);
    endtask : wr_at

    task automatic set_result(input logic [15:0] v);
        @(posedge sys_clk);
        prox_result <= v;
    endtask : set_result

    initial
    begin
        failures = 0;
        checked = 0;
        resetn = 1'b0;
        prox_result = 16'h0000;
        n = $urandom(40097);
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        for (k = 0; k < 8; k++)
        begin
            rd_at(offs[k], rd);
            check_byte(rd, rstv[k]);
        end
        host.command(prox_pkg::KIND_AUTO, prox_pkg::OFS_LOW_THRESH_LO_BYTE);
        for (k = 0; k < 4; k++)
        begin
            val[k] = 8'($urandom());
            host.send(1'b0, val[k]);
        end
        host.command(prox_pkg::KIND_AUTO, prox_pkg::OFS_LOW_THRESH_LO_BYTE);
        for (k = 0; k < 4; k++)
        begin
            host.recv(rd);
            check_byte(rd, val[k]);
        end
        wr_at(prox_pkg::OFS_LOW_THRESH_HI_BYTE, 8'h11);
        host.send(1'b0, 8'h01);
        host.recv(rd);
        host.recv(rd);
        check_byte(rd, 8'h01);
        // reserved kind must leave the pointer on the high byte, not move it to 0x08
        host.command(prox_pkg::KIND_REPEAT, prox_pkg::OFS_HIGH_THRESH_HI_BYTE);
        host.send(1'b1, 8'hC8);
        host.send(1'b1, 8'h02);
        rd_at(prox_pkg::OFS_HIGH_THRESH_HI_BYTE, rd);
        check_byte(rd, 8'h02);
        host.send(1'b1, 8'hE0);
        host.recv(rd);
        check_byte(rd, 8'h02);
        rd_at(prox_pkg::OFS_LOW_THRESH_HI_BYTE, rd);
        check_byte(rd, 8'h01);
        wr_at(prox_pkg::OFS_LOW_THRESH_LO_BYTE, 8'h00);
        wr_at(prox_pkg::OFS_HIGH_THRESH_LO_BYTE, 8'h00);
        wr_at(prox_pkg::OFS_WAIT_PERIOD, 8'hFE);
        wr_at(prox_pkg::OFS_INTEGRATION_PERIOD, 8'hFE);
        set_result(16'h0150);
        wr_at(prox_pkg::OFS_FUNCTION_ENABLES, 8'h2F);
        wait_on(1'b1);
        run_len(1'b1, n);
        check_cycles(n, 2 * STEP);
        run_len(1'b0, n);
        check_cycles(n, 3 + 3 * STEP);
        check_byte({7'h00, prox_irq}, 8'h01);
        rd_at(prox_pkg::OFS_STATUS, rd);
        check_byte(rd, 8'h20);
        host.send(1'b1, 8'hE5);
        check_byte({7'h00, prox_irq}, 8'h00);
        host.recv(rd);
        check_byte(rd, 8'h00);
        wr_at(prox_pkg::OFS_CONFIG, 8'h02);
        wr_at(prox_pkg::OFS_WAIT_PERIOD, 8'hFF);
        wait_on(1'b1);
        run_len(1'b1, n);
        run_len(1'b0, n);
        check_cycles(n, 3 + 12 * STEP + STEP);
        wr_at(prox_pkg::OFS_PERSIST, 8'h10);
        wr_at(prox_pkg::OFS_FUNCTION_ENABLES, 8'h27);
        rd_at(prox_pkg::OFS_FUNCTION_ENABLES, rd);
        check_byte(rd, 8'h27);
        for (k = 0; k < 12; k++)
        begin
            r = (k < 4) ? corner[k] : 16'($urandom_range(0, 16'h0300));
            set_result(r);
            wait_on(1'b1);
            host.send(1'b1, 8'hE5);
            check_byte({7'h00, prox_irq}, 8'h00);
            wait_on(1'b0);
            @(posedge sys_clk);
            #1;
            check_byte({7'h00, prox_irq}, {7'h00, outside(r)});
        end
        wr_at(prox_pkg::OFS_PERSIST, 8'h30);
        // an in-range result first, so the run counter starts from zero
        set_result(16'h0150);
        next_convert(rd[0]);
        host.send(1'b1, 8'hE5);
        set_result(16'h0050);
        for (k = 1; k < 4; k++)
        begin
            next_convert(rd[0]);
            check_byte({7'h00, rd[0]}, {7'h00, k == 3});
        end
        wr_at(prox_pkg::OFS_FUNCTION_ENABLES, 8'h07);
        wait_on(1'b1);
        host.send(1'b1, 8'hE5);
        next_convert(rd[0]);
        next_convert(rd[0]);
        check_byte({7'h00, rd[0]}, 8'h00);
        host.command(prox_pkg::KIND_REPEAT, prox_pkg::OFS_FUNCTION_ENABLES);
        wait_on(1'b0);
        host.send(1'b0, 8'h01);
        repeat (40) @(posedge sys_clk);
        n = 0;
        for (k = 0; k < 40; k++)
        begin
            @(posedge sys_clk);
            #1;
            n += (integrating === 1'b0) ? 0 : 1;
        end
        check_cycles(n, 0);
        host.send(1'b0, 8'h00);
        check_byte({7'h00, osc_run}, 8'h00);
        report_and_stop();
    end
endmodule : tb_top
